// *** sim/aip_cmd_bench.sv ***
// Self-checking bench for the idle and geometry command engine.
`timescale 1ns/1ps
`default_nettype none
module aip_cmd_bench
    import aip_pkg::*;
;
    localparam int TK = 4; // Short one-second tick keeps runs brief.
    logic clk, nrst, host_access, soft_reset, reset_reverts;
    logic motor_at_speed, cmd_wr, spindle_on, idle_mode, standby_mode;
    logic [7:0] cmd_code, sect_count, dev_head, ident_addr, st, er;
    logic [7:0] geom_sectors;
    logic [3:0] geom_heads_m1;
    logic [15:0] cur_cylinders, ident_word;
    int error_cnt = 0;
    int n_compared = 0;
    bit ok;
    int n;

    aip_cmd #(.TICK_CYCLES(TK)) u_aip_cmd (.clk(clk), .nrst(nrst),
        .cmd_wr(cmd_wr), .cmd_code(cmd_code), .sect_count(sect_count),
        .dev_head(dev_head), .host_access(host_access),
        .soft_reset(soft_reset), .reset_reverts(reset_reverts),
        .motor_at_speed(motor_at_speed), .ident_addr(ident_addr),
        .cur_cylinders(cur_cylinders), .command_status_flags(st),
        .command_error_flags(er), .spindle_on(spindle_on),
        .idle_mode(idle_mode), .standby_mode(standby_mode),
        .geom_sectors(geom_sectors), .geom_heads_m1(geom_heads_m1),
        .ident_word(ident_word));

    aip_host_model u_aip_host_model (.clk(clk), .status(st),
        .cmd_wr(cmd_wr), .cmd_code(cmd_code), .sect_count(sect_count),
        .dev_head(dev_head));

    // Free-running 40 MHz clock.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Prints the verdict and stops the run.
    task automatic end_of_test();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Compares one value and reports a difference at once.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Issues a command; a hang counts as a failure and ends the run.
    task automatic cmd(input logic [7:0] op, input logic [7:0] sc,
        input logic [3:0] hm1);
        u_aip_host_model.issue(op, sc, hm1, ok, n);
        if (!ok) begin
            error_cnt++;
            end_of_test();
        end
    endtask

    // Reads one identify word, which lands one cycle after the index.
    task automatic rd_id(input logic [7:0] a, input logic [15:0] exp);
        ident_addr = a;
        @(negedge clk);
        chk(ident_word, exp);
    endtask

    // Waits a bounded time for standby and returns the cycles taken.
    task automatic wait_sb(input int lim);
        n = 0;
        while (standby_mode !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        // A wait that runs out is a failure and ends the run.
        if (standby_mode !== 1'b1) begin
            error_cnt++;
            end_of_test();
        end
    endtask

    // Idle at speed, then a host access restarts the countdown.
    task automatic t_idle_restart();
        motor_at_speed = 1'b1;
        cmd(AIP_OP_IDLE, 8'h01, 4'h0);
        chk(16'(n), 16'h0001);
        chk({st, 5'h0, idle_mode, spindle_on, standby_mode}, 16'h5006);
        repeat (12) @(negedge clk);
        host_access = 1'b1;
        @(negedge clk);
        host_access = 1'b0;
        repeat (16) @(negedge clk);
        chk(16'(standby_mode), 16'h0000);
        wait_sb(12);
        chk({st, 5'h0, idle_mode, spindle_on, standby_mode}, 16'h0001);
        motor_at_speed = 1'b0;
    endtask

    // Codes 1, 240, 241, 252 and 255 land in standby after their own decoded time.
    task automatic t_codes();
        logic [7:0] codes[5] = '{8'h01, 8'hF0, 8'hF1, 8'hFC, 8'hFF};
        int secs[5] = '{5, 1200, 1800, 1260, 1275};
        bit in_win; // Standby came inside the expected window.
        motor_at_speed = 1'b1;
        for (int i = 0; i < 5; i++) begin
            cmd(i[0] ? AIP_OP_IDLE_ALT : AIP_OP_IDLE, codes[i], 4'h0);
            wait_sb(secs[i] * TK + 10);
            in_win = n >= secs[i] * TK - 3 && n <= secs[i] * TK + 4;
            chk(16'(in_win), 16'h0001);
        end
        // The eight hour code must still hold off standby after 1300 seconds.
        cmd(AIP_OP_IDLE, AIP_CODE_8H, 4'h0);
        repeat (1300 * TK) @(negedge clk);
        chk(16'(standby_mode), 16'h0000);
        cmd(AIP_OP_IDLE, AIP_CODE_OFF, 4'h0);
        motor_at_speed = 1'b0;
    endtask

    // Idle immediate from idle, motor not at speed, waits for the spindle, never arms.
    task automatic t_imm();
        fork
            cmd(AIP_OP_IDLE_IMM_ALT, 8'h01, 4'h0);
            begin
                repeat (10) @(negedge clk);
                chk({st[AIP_ST_BSY], spindle_on}, 16'h0003);
                motor_at_speed = 1'b1;
            end
        join
        chk({idle_mode, standby_mode}, 16'h0002);
        repeat (60) @(negedge clk);
        chk(16'(standby_mode), 16'h0000);
        cmd(AIP_OP_IDLE_IMM, 8'h00, 4'h0);
        chk(16'(n), 16'h0001);
    endtask

    // Reserved code and unknown opcode abort; code zero never expires.
    task automatic t_abort();
        cmd(AIP_OP_IDLE, AIP_CODE_ABORT, 4'h0);
        chk({st, er}, 16'h5104);
        chk({idle_mode, standby_mode}, 16'h0002);
        cmd(8'h00, 8'h00, 4'h0);
        chk({st, er}, 16'h5104);
        cmd(AIP_OP_IDLE, AIP_CODE_OFF, 4'h0);
        chk({st, er}, 16'h5000);
        repeat (100) @(negedge clk);
        chk(16'(standby_mode), 16'h0000);
    endtask

    // Geometry is stored, reported and reverted only on a reverting reset.
    task automatic t_geom();
        logic [31:0] cap;
        cmd(AIP_OP_SET_GEOM, 8'h00, 4'h5);
        chk({geom_sectors, 4'h0, geom_heads_m1}, 16'h0005);
        rd_id(AIP_ID_CYL, cur_cylinders);
        rd_id(AIP_ID_HEADS, 16'h0006);
        rd_id(AIP_ID_SECT, 16'h0000);
        cmd(AIP_OP_SET_GEOM, 8'h11, 4'h9);
        cap = 32'(cur_cylinders) * 32'd10 * 32'd17;
        rd_id(AIP_ID_CAP_LO, cap[15:0]);
        rd_id(AIP_ID_CAP_HI, cap[31:16]);
        for (int i = 0; i < 2; i++) begin
            reset_reverts = i[0];
            soft_reset = 1'b1;
            @(negedge clk);
            soft_reset = 1'b0;
            repeat (2) @(negedge clk);
            chk({geom_sectors, 4'h0, geom_heads_m1},
                i[0] ? 16'h3F0F : 16'h1109);
        end
    endtask

    // Main sequence: all inputs set at time zero, then reset and tests.
    initial begin
        nrst = 1'b0;
        host_access = 1'b0;
        soft_reset = 1'b0;
        reset_reverts = 1'b0;
        motor_at_speed = 1'b0;
        ident_addr = 8'h00;
        cur_cylinders = 16'h1234;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        repeat (5) @(negedge clk);
        chk({st, geom_sectors}, 16'h003F);
        chk({geom_heads_m1, 3'h0, standby_mode}, 16'h00F1);
        t_idle_restart();
        t_codes();
        t_imm();
        t_abort();
        t_geom();
        end_of_test();
    end
endmodule // aip_cmd_bench
`default_nettype wire

// *** sim/aip_host_model.sv ***
// Host controller model that writes the command block registers.
`timescale 1ns/1ps
`default_nettype none
module aip_host_model
    import aip_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] status,
    output logic cmd_wr,
    output logic [7:0] cmd_code,
    output logic [7:0] sect_count,
    output logic [7:0] dev_head
);
    // The bus starts idle with no command pending.
    initial begin
        cmd_wr = 1'b0;
        cmd_code = 8'h00;
        sect_count = 8'h00;
        dev_head = 8'hA0;
    end

    // Writes one command, then waits a bounded time for busy to clear.
    task automatic issue(input logic [7:0] op, input logic [7:0] sc,
        input logic [3:0] hm1, output bit ok, output int n);
        @(negedge clk);
        cmd_code = op;
        sect_count = sc;
        dev_head = {4'hA, hm1};
        cmd_wr = 1'b1;
        @(negedge clk);
        cmd_wr = 1'b0;
        // Released fields are scrambled so no stale value looks valid.
        cmd_code = ~op;
        sect_count = ~sc;
        dev_head = ~dev_head;
        // Busy stands for a single cycle on a fast command, so look now.
        ok = status[AIP_ST_BSY] === 1'b1;
        n = 0;
        while (status[AIP_ST_BSY] !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        ok = ok && n < 200;
    endtask
endmodule // aip_host_model
`default_nettype wire

// *** src/aip_cmd.sv ***
// Idle, idle immediate and geometry command engine of the drive.
// Contract
// - Idle enters idle, loads and starts timer.
// - Spin up only when not spinning.
// - Zero code disables power down, nonzero enables.
// - Codes 1-240 times five; 241-251 half hours.
// - 252,253,255 fixed intervals; 254 aborts command.
// - Expired interval without access enters standby; the code drops an expiry that comes while in AIP_SPIN.
// - Host access restarts the full interval.
// - Idle immediate enters idle, spins up if needed.
// - Idle immediate keeps the timer setting.
// - Geometry command stores sectors and heads minus one.
// - Identify words 54-58 report stored geometry.
// - Geometry kept until new command, power, reverting reset.
// - Zero sectors means zero, not 256.
`timescale 1ns/1ps
`default_nettype none
module aip_cmd
    import aip_pkg::*;
#(
    parameter int TICK_CYCLES = AIP_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic cmd_wr,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] sect_count,
    input wire logic [7:0] dev_head,
    input wire logic host_access,
    input wire logic soft_reset,
    input wire logic reset_reverts,
    input wire logic motor_at_speed,
    input wire logic [7:0] ident_addr,
    input wire logic [15:0] cur_cylinders,
    output logic [7:0] command_status_flags,
    output logic [7:0] command_error_flags,
    output logic spindle_on,
    output logic idle_mode,
    output logic standby_mode,
    output logic [7:0] geom_sectors,
    output logic [3:0] geom_heads_m1,
    output logic [15:0] ident_word
);
    logic rst_s1, rst_n; // Reset release synchroniser.
    aip_state_t st_reg, st_next; // Command engine state.
    logic [7:0] op_reg, op_next; // Latched opcode.
    logic [7:0] sc_reg, sc_next; // Latched sector count.
    logic [7:0] dh_reg, dh_next; // Latched device/head byte.
    logic busy_reg, busy_next; // Busy flag.
    logic err_reg, err_next; // Error status flag.
    logic abt_reg, abt_next; // Abort flag.
    logic spin_reg, spin_next; // Spindle drive request.
    logic idle_reg, idle_next; // Idle power mode.
    logic stby_reg, stby_next; // Standby power mode.
    logic [7:0] gsec_reg, gsec_next; // Stored sectors per track.
    logic [3:0] ghd_reg, ghd_next; // Stored heads minus one.
    logic [15:0] idw_reg, idw_next; // Identify word being read.
    logic t_arm; // Load the standby timer.
    logic t_stop; // Halt the timer on entry to standby.
    logic t_expire; // Timer ran out.
    logic [AIP_SEC_W-1:0] t_secs; // Decoded interval.
    logic [27:0] capacity; // Sectors reachable through the geometry.

    // Reset is released through two flops; assertion stays asynchronous.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    assign t_secs = aip_code_secs(sc_reg);

    // Command decode and power mode logic. Only the engine state and
    // its latches move here; the countdown lives in the timer module.
    always_comb begin
        st_next = st_reg;
        op_next = op_reg;
        sc_next = sc_reg;
        dh_next = dh_reg;
        busy_next = busy_reg;
        err_next = err_reg;
        abt_next = abt_reg;
        spin_next = spin_reg;
        idle_next = idle_reg;
        stby_next = stby_reg;
        gsec_next = gsec_reg;
        ghd_next = ghd_reg;
        t_arm = 1'b0;
        t_stop = 1'b0;
        unique case (st_reg)
            AIP_READY: begin
                // Commands written while busy are not taken.
                if (cmd_wr) begin
                    op_next = cmd_code;
                    sc_next = sect_count;
                    dh_next = dev_head;
                    busy_next = 1'b1;
                    err_next = 1'b0;
                    abt_next = 1'b0;
                    st_next = AIP_EXEC;
                end
            end
            AIP_EXEC: begin
                st_next = AIP_READY;
                busy_next = 1'b0;
                if (aip_is_idle(op_reg) && sc_reg == AIP_CODE_ABORT) begin
                    // The abort code leaves mode and timer untouched.
                    err_next = 1'b1;
                    abt_next = 1'b1;
                end else if (aip_is_idle(op_reg) || aip_is_imm(op_reg)) begin
                    idle_next = 1'b1;
                    stby_next = 1'b0;
                    spin_next = 1'b1;
                    t_arm = aip_is_idle(op_reg);
                    if (!motor_at_speed) begin
                        // Busy stays up until the spindle is at speed.
                        busy_next = 1'b1;
                        st_next = AIP_SPIN;
                    end
                end else if (op_reg == AIP_OP_SET_GEOM) begin
                    // Zero is stored as zero sectors per track.
                    gsec_next = sc_reg;
                    ghd_next = dh_reg[AIP_DH_HEAD_LSB +: AIP_DH_HEAD_W];
                end else begin
                    // Opcodes this engine does not own are refused.
                    err_next = 1'b1;
                    abt_next = 1'b1;
                end
            end
            AIP_SPIN: begin
                if (motor_at_speed) begin
                    busy_next = 1'b0;
                    st_next = AIP_READY;
                end
            end
            default: begin
                st_next = AIP_READY;
                busy_next = 1'b0;
            end
        endcase
        // The drive stops its spindle once the interval passes untouched while the engine is in AIP_READY.
        if (t_expire && st_reg == AIP_READY) begin
            stby_next = 1'b1;
            idle_next = 1'b0;
            spin_next = 1'b0;
            t_stop = 1'b1;
        end
        // A reset with the reverting feature in force drops the geometry.
        if (soft_reset && reset_reverts) begin
            gsec_next = AIP_GEOM_SECT_RST;
            ghd_next = AIP_GEOM_HEAD_RST;
        end
    end

    // Engine registers; power-off restores the default geometry.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= AIP_READY;
            op_reg <= 8'h00;
            sc_reg <= 8'h00;
            dh_reg <= 8'h00;
            busy_reg <= 1'b0;
            err_reg <= 1'b0;
            abt_reg <= 1'b0;
            spin_reg <= 1'b0;
            idle_reg <= 1'b0;
            stby_reg <= 1'b1;
            gsec_reg <= AIP_GEOM_SECT_RST;
            ghd_reg <= AIP_GEOM_HEAD_RST;
        end else begin
            st_reg <= st_next;
            op_reg <= op_next;
            sc_reg <= sc_next;
            dh_reg <= dh_next;
            busy_reg <= busy_next;
            err_reg <= err_next;
            abt_reg <= abt_next;
            spin_reg <= spin_next;
            idle_reg <= idle_next;
            stby_reg <= stby_next;
            gsec_reg <= gsec_next;
            ghd_reg <= ghd_next;
        end
    end

    // Every command write counts as a drive access too.
    aip_standby_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .arm(t_arm),
        .arm_secs(t_secs),
        .restart(host_access || cmd_wr),
        .stop(t_stop),
        .running(),
        .expire(t_expire)
    );

    // Capacity is cylinders times heads times sectors per track.
    // Every operand is widened first so no partial product is cut short.
    assign capacity = 28'(cur_cylinders) * (28'(ghd_reg) + 28'h1) *
        28'(gsec_reg);

    // Identify words that follow the stored geometry.
    always_comb begin
        unique case (ident_addr)
            AIP_ID_CYL: idw_next = cur_cylinders;
            AIP_ID_HEADS: idw_next = 16'(ghd_reg) + 16'h0001;
            AIP_ID_SECT: idw_next = 16'(gsec_reg);
            AIP_ID_CAP_LO: idw_next = capacity[15:0];
            AIP_ID_CAP_HI: idw_next = 16'(capacity[27:16]);
            default: idw_next = 16'h0000;
        endcase
    end

    // Identify word register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idw_reg <= 16'h0000;
        end else begin
            idw_reg <= idw_next;
        end
    end

    // Status: ready and seek complete follow the idle state; the other
    // bits of both registers read as zero apart from busy, error and abort.
    assign command_status_flags = {busy_reg, !busy_reg && !stby_reg, 1'b0,
        spin_reg && !busy_reg, 3'b000, err_reg};
    assign command_error_flags = {5'b00000, abt_reg, 2'b00};
    assign spindle_on = spin_reg;
    assign idle_mode = idle_reg;
    assign standby_mode = stby_reg;
    assign geom_sectors = gsec_reg;
    assign geom_heads_m1 = ghd_reg;
    assign ident_word = idw_reg;

    sequence s_take;
        st_reg == AIP_READY && cmd_wr;
    endsequence
    sequence s_exec_idle_abort;
        st_reg == AIP_EXEC && aip_is_idle(op_reg) && sc_reg == AIP_CODE_ABORT;
    endsequence

    a_take_busy: assert property (@(posedge clk) disable iff (!rst_n)
        s_take |=> busy_reg && !err_reg && !abt_reg)
        else $error("taken command did not raise busy");
    a_abort_code: assert property (@(posedge clk) disable iff (!rst_n)
        s_exec_idle_abort |=> !busy_reg && err_reg && abt_reg &&
        $stable(idle_reg))
        else $error("code 254 did not abort");
    a_idle_fast: assert property (@(posedge clk) disable iff (!rst_n)
        st_reg == AIP_EXEC && (aip_is_idle(op_reg) || aip_is_imm(op_reg)) &&
        sc_reg != AIP_CODE_ABORT && motor_at_speed |=> !busy_reg &&
        idle_reg && !err_reg)
        else $error("spinning drive delayed the idle command");
    a_spin_wait: assert property (@(posedge clk) disable iff (!rst_n)
        st_reg == AIP_EXEC && aip_is_imm(op_reg) && !motor_at_speed
        |=> busy_reg && spindle_on ##1 (busy_reg || $past(motor_at_speed)))
        else $error("idle immediate skipped the spin up");
    a_arm_idle: assert property (@(posedge clk) disable iff (!rst_n)
        t_arm |-> aip_is_idle(op_reg) && st_reg == AIP_EXEC)
        else $error("timer loaded by a command other than idle");
    a_geom_store: assert property (@(posedge clk) disable iff (!rst_n)
        st_reg == AIP_EXEC && op_reg == AIP_OP_SET_GEOM && !soft_reset
        |=> gsec_reg == $past(sc_reg) && ghd_reg == $past(dh_reg[3:0]))
        else $error("geometry not stored");
    a_geom_keep: assert property (@(posedge clk) disable iff (!rst_n)
        !(st_reg == AIP_EXEC && op_reg == AIP_OP_SET_GEOM) &&
        !(soft_reset && reset_reverts) |=> $stable(gsec_reg) &&
        $stable(ghd_reg))
        else $error("geometry changed without cause");
    a_standby_entry: assert property (@(posedge clk)
        disable iff (!rst_n) t_expire && st_reg == AIP_READY |=> stby_reg &&
        !spin_reg)
        else $error("expiry did not enter standby");
endmodule // aip_cmd
`default_nettype wire

// *** src/aip_pkg.sv ***
// Package of opcodes, register fields, timer codes and time constants.
package aip_pkg;
    // Command opcodes; both idle commands have an alternate code.
    localparam logic [7:0] AIP_OP_IDLE = 8'hE3;
    localparam logic [7:0] AIP_OP_IDLE_ALT = 8'h97;
    localparam logic [7:0] AIP_OP_IDLE_IMM = 8'hE1;
    localparam logic [7:0] AIP_OP_IDLE_IMM_ALT = 8'h95;
    localparam logic [7:0] AIP_OP_SET_GEOM = 8'h91;
    // Bit positions in the status flags.
    localparam int AIP_ST_BSY = 7;
    localparam int AIP_ST_RDY = 6;
    localparam int AIP_ST_DSC = 4;
    localparam int AIP_ST_ERR = 0;
    // Bit position of the abort flag in the error flags.
    localparam int AIP_ER_ABT = 2;
    // Field of the device/head byte that carries heads minus one.
    localparam int AIP_DH_HEAD_LSB = 0;
    localparam int AIP_DH_HEAD_W = 4;
    // Standby timer codes.
    localparam logic [7:0] AIP_CODE_OFF = 8'h00;
    localparam logic [7:0] AIP_CODE_LIN_MAX = 8'hF0;
    localparam logic [7:0] AIP_CODE_HALF_MAX = 8'hFB;
    localparam logic [7:0] AIP_CODE_21M = 8'hFC;
    localparam logic [7:0] AIP_CODE_8H = 8'hFD;
    localparam logic [7:0] AIP_CODE_ABORT = 8'hFE;
    localparam logic [7:0] AIP_CODE_21M15 = 8'hFF;
    // Interval figures in seconds.
    localparam int AIP_LIN_STEP_S = 5;
    localparam int AIP_HALF_STEP_S = 30 * 60;
    localparam int AIP_T21M_S = 21 * 60;
    localparam int AIP_T8H_S = 8 * 60 * 60;
    localparam int AIP_T21M15_S = 21 * 60 + 15;
    localparam int AIP_SEC_W = 16;
    // Clock rate and the one-second tick derived from it.
    localparam int AIP_CLK_HZ = 40_000_000;
    localparam int AIP_TICK_S = 1;
    localparam int AIP_TICK_CYCLES = AIP_CLK_HZ * AIP_TICK_S;
    // Geometry after power-up or a reverting soft reset.
    localparam logic [7:0] AIP_GEOM_SECT_RST = 8'h3F;
    localparam logic [3:0] AIP_GEOM_HEAD_RST = 4'hF;
    // Identify data words that reflect the geometry.
    localparam logic [7:0] AIP_ID_CYL = 8'h36;
    localparam logic [7:0] AIP_ID_HEADS = 8'h37;
    localparam logic [7:0] AIP_ID_SECT = 8'h38;
    localparam logic [7:0] AIP_ID_CAP_LO = 8'h39;
    localparam logic [7:0] AIP_ID_CAP_HI = 8'h3A;

    // Command engine states.
    typedef enum logic [1:0] {
        AIP_READY = 2'b00,
        AIP_EXEC = 2'b01,
        AIP_SPIN = 2'b10
    } aip_state_t;

    // Converts a timer code into seconds; zero and the abort code give 0.
    function automatic logic [AIP_SEC_W-1:0] aip_code_secs(
        input logic [7:0] c);
        logic [31:0] s;
        s = 32'h0;
        if (c == AIP_CODE_OFF || c == AIP_CODE_ABORT) begin
            s = 32'h0;
        end else if (c <= AIP_CODE_LIN_MAX) begin
            s = 32'(c) * 32'(AIP_LIN_STEP_S);
        end else if (c <= AIP_CODE_HALF_MAX) begin
            s = 32'(c - AIP_CODE_LIN_MAX) * 32'(AIP_HALF_STEP_S);
        end else if (c == AIP_CODE_21M) begin
            s = 32'(AIP_T21M_S);
        end else if (c == AIP_CODE_8H) begin
            s = 32'(AIP_T8H_S);
        end else begin
            s = 32'(AIP_T21M15_S);
        end
        return s[AIP_SEC_W-1:0];
    endfunction

    // True for either idle opcode.
    function automatic logic aip_is_idle(input logic [7:0] op);
        return op == AIP_OP_IDLE || op == AIP_OP_IDLE_ALT;
    endfunction

    // True for either idle immediate opcode.
    function automatic logic aip_is_imm(input logic [7:0] op);
        return op == AIP_OP_IDLE_IMM || op == AIP_OP_IDLE_IMM_ALT;
    endfunction
endpackage

// *** src/aip_standby_timer.sv ***
// Standby countdown with its own one-second prescaler.
`timescale 1ns/1ps
`default_nettype none
module aip_standby_timer
    import aip_pkg::*;
#(
    parameter int TICK_CYCLES = AIP_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic arm,
    input wire logic [AIP_SEC_W-1:0] arm_secs,
    input wire logic restart,
    input wire logic stop,
    output logic running,
    output logic expire
);
    logic [31:0] pre_reg, pre_next; // Cycles within the current second.
    logic [AIP_SEC_W-1:0] left_reg, left_next; // Seconds still to run.
    logic [AIP_SEC_W-1:0] ivl_reg, ivl_next; // Programmed interval.
    logic run_reg, run_next; // Countdown is enabled.
    logic exp_reg, exp_next; // One-cycle expiry pulse.
    logic tick; // One-second enable.

    assign tick = pre_reg == 32'(TICK_CYCLES - 1);

    // Next-state logic. A host access restarts the prescaler as well, so a
    // restarted interval is never shortened by a partly spent second.
    always_comb begin
        pre_next = tick ? 32'h0 : pre_reg + 32'h1;
        left_next = left_reg;
        ivl_next = ivl_reg;
        run_next = run_reg;
        exp_next = 1'b0;
        if (arm) begin
            // A zero interval disables the power down.
            ivl_next = arm_secs;
            left_next = arm_secs;
            run_next = arm_secs != '0;
            pre_next = 32'h0;
        end else if (stop) begin
            run_next = 1'b0;
        end else if (restart && run_reg) begin
            left_next = ivl_reg;
            pre_next = 32'h0;
        end else if (run_reg && tick) begin
            if (left_reg == AIP_SEC_W'(1)) begin
                run_next = 1'b0;
                exp_next = 1'b1;
            end else begin
                left_next = left_reg - AIP_SEC_W'(1);
            end
        end
    end

    // State registers.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_reg <= 32'h0;
            left_reg <= '0;
            ivl_reg <= '0;
            run_reg <= 1'b0;
            exp_reg <= 1'b0;
        end else begin
            pre_reg <= pre_next;
            left_reg <= left_next;
            ivl_reg <= ivl_next;
            run_reg <= run_next;
            exp_reg <= exp_next;
        end
    end

    assign running = run_reg;
    assign expire = exp_reg;

    a_zero_disables: assert property (@(posedge clk)
        disable iff (!rst_n) arm && arm_secs == '0 |=> !run_reg)
        else $error("zero interval left the timer running");
    a_restart_full: assert property (@(posedge clk) disable iff (!rst_n)
        !arm && !stop && restart && run_reg |=> left_reg == $past(ivl_reg))
        else $error("access did not restart the full interval");
    a_expire_after: assert property (@(posedge clk) disable iff (!rst_n)
        run_reg && tick && left_reg == AIP_SEC_W'(1) && !arm && !stop &&
        !restart |=> expire && !run_reg)
        else $error("interval elapsed without expiry");
    a_hold_interval: assert property (@(posedge clk)
        disable iff (!rst_n) !arm |=> ivl_reg == $past(ivl_reg))
        else $error("interval changed without an idle command");
endmodule // aip_standby_timer
`default_nettype wire
